// file: ofm_map.vh
`ifndef OFM_MAP_VH
`define OFM_MAP_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define OFM_ADDR_KEY      32'h4004_0800
`define OFM_ADDR_EN       32'h4004_0804
`define OFM_ADDR_LO_BYP   32'h4004_0808
`define OFM_ADDR_LO_ACT   32'h4004_080C
`define OFM_ADDR_HI_BYP   32'h4004_0810
`define OFM_ADDR_HI_ACT   32'h4004_0814
// ----------------------------------------
// codes and reset values
// ----------------------------------------
`define OFM_KEY_PROTECT   8'h06
`define OFM_KEY_UNLOCK    8'hF9
`define OFM_EN_OFF        8'h00
`define OFM_EN_ON         8'hE4
`define OFM_LO_RST        32'h0000_0000
`define OFM_HI_RST        32'hFFFF_FFFF
// ----------------------------------------
// field layout
// ----------------------------------------
`define OFM_CODE_MSB      7
`define OFM_LIMIT_MSB     31
// ----------------------------------------
// timing
// ----------------------------------------
`define OFM_CLK_KHZ       20000
`define OFM_REF_KHZ       9500
`define OFM_REF_TOL_PCT   10
`define OFM_WINDOW_US     8
`define OFM_WINDOW_CYC    ((`OFM_WINDOW_US * `OFM_CLK_KHZ) / 1000)
`define OFM_PERSIST_US    32
`define OFM_PERSIST_WIN   (`OFM_PERSIST_US / `OFM_WINDOW_US)
`endif

// file: ofm_top.v
// The implementer's own choice: the strobed register port.
`timescale 1ns/1ps
`include "ofm_map.vh"

module ofm_top (
    input  wire        clk_i,
    input  wire        rst_n_i,
    input  wire        ce_i,
    input  wire [31:0] addr_i,
    input  wire [31:0] wdata_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rdata_o,
    input  wire        mon_clk_i,
    input  wire        pll_active_select_i,
    input  wire        stop_mode_i,
    input  wire        warmup_done_i,
    output reg         fault_rst_o,
    output reg         io_hiz_o,
    output reg         monitor_on_o,
    output reg         osc_stopped_o
);

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function hit;
        input [31:0] a;
        input [31:0] ref_a;
        begin
            hit = (a == ref_a);
        end
    endfunction

    function out_of_range;
        input [31:0] cnt;
        input [31:0] lo;
        input [31:0] hi;
        begin
            out_of_range = (cnt < lo) || (cnt > hi);
        end
    endfunction

    // enable register takes only its two codes
    function en_code_ok;
        input [7:0] d;
        begin
            en_code_ok = (d == `OFM_EN_ON) || (d == `OFM_EN_OFF);
        end
    endfunction

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    localparam [31:0] WIN_CYC      = `OFM_WINDOW_CYC;
    localparam [31:0] PERSIST_WIN  = `OFM_PERSIST_WIN;
    localparam [15:0] WIN_LAST     = WIN_CYC[15:0] - 16'h0001;
    localparam [7:0]  PERSIST_LAST = PERSIST_WIN[7:0] - 8'h01;

    reg  [`OFM_CODE_MSB:0]  write_unlock_key;
    reg  [`OFM_CODE_MSB:0]  monitor_enable_code;
    reg  [`OFM_LIMIT_MSB:0] low_limit_pll_bypassed;
    reg  [`OFM_LIMIT_MSB:0] low_limit_pll_active;
    reg  [`OFM_LIMIT_MSB:0] high_limit_pll_bypassed;
    reg  [`OFM_LIMIT_MSB:0] high_limit_pll_active;

    reg  [1:0]  mon_sync;
    reg         mon_prev;
    reg  [1:0]  pll_sync;
    reg  [1:0]  stop_sync;
    reg  [1:0]  warm_sync;

    reg  [15:0] win_cnt;
    reg  [31:0] edge_cnt;
    reg  [7:0]  bad_run;
    reg  [7:0]  good_run;
    reg         force_bypassed;
    reg         fault;

    wire        unlocked;
    wire        mon_en;
    wire        active;
    wire        limit_wr_ok;
    wire        mon_edge;
    wire        win_end;
    wire        use_active;
    wire [31:0] sel_lo;
    wire [31:0] sel_hi;
    wire [31:0] final_cnt;
    wire        win_bad;
    wire        win_stop;
    wire        wr_key;
    wire        wr_en;
    wire        wr_lo_byp;
    wire        wr_lo_act;
    wire        wr_hi_byp;
    wire        wr_hi_act;
    wire        fault_set;
    wire        fault_clr;

    // ----------------------------------------
    // control decode
    // ----------------------------------------
    assign unlocked    = (write_unlock_key == `OFM_KEY_UNLOCK);
    assign mon_en      = (monitor_enable_code == `OFM_EN_ON);
    // stop suspends, warm-up end resumes
    assign active      = mon_en && !stop_sync[1] && warm_sync[1];
    assign limit_wr_ok = wr_i && unlocked && !mon_en;

    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mon_sync  <= 2'h0;
            mon_prev  <= 1'b0;
            pll_sync  <= 2'h0;
            stop_sync <= 2'h0;
            warm_sync <= 2'h0;
        end else if (ce_i) begin
            mon_sync  <= {mon_sync[0], mon_clk_i};
            mon_prev  <= mon_sync[1];
            pll_sync  <= {pll_sync[0], pll_active_select_i};
            stop_sync <= {stop_sync[0], stop_mode_i};
            warm_sync <= {warm_sync[0], warmup_done_i};
        end
    end

    // monitored clock must stay below half of clk_i to be counted
    assign mon_edge = mon_sync[1] && !mon_prev;

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    // key writes are never gated; everything else needs the unlock code
    assign wr_key    = wr_i && hit(addr_i, `OFM_ADDR_KEY);
    assign wr_en     = wr_i && unlocked && hit(addr_i, `OFM_ADDR_EN);
    assign wr_lo_byp = limit_wr_ok && hit(addr_i, `OFM_ADDR_LO_BYP);
    assign wr_lo_act = limit_wr_ok && hit(addr_i, `OFM_ADDR_LO_ACT);
    assign wr_hi_byp = limit_wr_ok && hit(addr_i, `OFM_ADDR_HI_BYP);
    assign wr_hi_act = limit_wr_ok && hit(addr_i, `OFM_ADDR_HI_ACT);

    // ----------------------------------------
    // key register
    // ----------------------------------------
    // only the external reset reaches these; the fault output does not
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            write_unlock_key <= `OFM_KEY_PROTECT;
        end else if (ce_i) begin
            if (wr_key) begin
                if (wdata_i[`OFM_CODE_MSB:0] == `OFM_KEY_UNLOCK) begin
                    write_unlock_key <= `OFM_KEY_UNLOCK;
                end else begin
                    write_unlock_key <= `OFM_KEY_PROTECT;
                end
            end
        end
    end

    // ----------------------------------------
    // enable register
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            monitor_enable_code <= `OFM_EN_OFF;
        end else if (ce_i) begin
            if (wr_en && en_code_ok(wdata_i[`OFM_CODE_MSB:0])) begin
                monitor_enable_code <= wdata_i[`OFM_CODE_MSB:0];
            end
        end
    end

    // ----------------------------------------
    // limit registers
    // ----------------------------------------
    // a blocked write just drops; the bus has no error response to give
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_limit_pll_bypassed <= `OFM_LO_RST;
        end else if (ce_i && wr_lo_byp) begin
            low_limit_pll_bypassed <= wdata_i;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_limit_pll_active <= `OFM_LO_RST;
        end else if (ce_i && wr_lo_act) begin
            low_limit_pll_active <= wdata_i;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            high_limit_pll_bypassed <= `OFM_HI_RST;
        end else if (ce_i && wr_hi_byp) begin
            high_limit_pll_bypassed <= wdata_i;
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            high_limit_pll_active <= `OFM_HI_RST;
        end else if (ce_i && wr_hi_act) begin
            high_limit_pll_active <= wdata_i;
        end
    end

    // ----------------------------------------
    // read port
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (ce_i) begin
            if (rd_i) begin
                if (hit(addr_i, `OFM_ADDR_KEY)) begin
                    rdata_o <= {24'h000000, write_unlock_key};
                end else if (hit(addr_i, `OFM_ADDR_EN)) begin
                    rdata_o <= {24'h000000, monitor_enable_code};
                end else if (hit(addr_i, `OFM_ADDR_LO_BYP)) begin
                    rdata_o <= low_limit_pll_bypassed;
                end else if (hit(addr_i, `OFM_ADDR_LO_ACT)) begin
                    rdata_o <= low_limit_pll_active;
                end else if (hit(addr_i, `OFM_ADDR_HI_BYP)) begin
                    rdata_o <= high_limit_pll_bypassed;
                end else if (hit(addr_i, `OFM_ADDR_HI_ACT)) begin
                    rdata_o <= high_limit_pll_active;
                end else begin
                    rdata_o <= 32'h0000_0000;
                end
            end else begin
                rdata_o <= 32'h0000_0000;
            end
        end
    end

    // ----------------------------------------
    // limit selection
    // ----------------------------------------
    assign use_active = pll_sync[1] && !force_bypassed;
    assign sel_lo     = use_active ? low_limit_pll_active : low_limit_pll_bypassed;
    assign sel_hi     = use_active ? high_limit_pll_active : high_limit_pll_bypassed;

    // ----------------------------------------
    // measurement window
    // ----------------------------------------
    // clk_i stands in for the 20 MHz reference (OFM_CLK_KHZ); limits scale with it
    assign win_end   = (win_cnt == WIN_LAST);
    assign final_cnt = edge_cnt + {31'h00000000, mon_edge};
    assign win_bad   = out_of_range(final_cnt, sel_lo, sel_hi);
    assign win_stop  = (final_cnt == 32'h0000_0000);

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            win_cnt  <= 16'h0000;
            edge_cnt <= 32'h0000_0000;
        end else if (ce_i) begin
            if (!active || win_end) begin
                win_cnt  <= 16'h0000;
                edge_cnt <= 32'h0000_0000;
            end else begin
                win_cnt  <= win_cnt + 16'h0001;
                edge_cnt <= final_cnt;
            end
        end
    end

    // ----------------------------------------
    // persistence and fault reset
    // ----------------------------------------
    // a stopped oscillator counts zero edges (win_stop) and raises the fault like a bad window;
    // it clears when edges return and a good run completes, or at once when monitoring stops
    assign fault_set = active && win_end && (win_bad || win_stop) &&
                       (bad_run == PERSIST_LAST);
    assign fault_clr = !active ||
                       (win_end && !win_bad && !win_stop && (good_run == PERSIST_LAST));

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bad_run  <= 8'h00;
            good_run <= 8'h00;
            fault    <= 1'b0;
        end else if (ce_i) begin
            if (!active) begin
                bad_run  <= 8'h00;
                good_run <= 8'h00;
                fault    <= 1'b0;
            end else if (win_end) begin
                if (win_bad || win_stop) begin
                    good_run <= 8'h00;
                    if (fault_set) begin
                        fault <= 1'b1;
                    end else begin
                        bad_run <= bad_run + 8'h01;
                    end
                end else begin
                    bad_run <= 8'h00;
                    if (fault_clr) begin
                        fault <= 1'b0;
                    end else if (fault) begin
                        good_run <= good_run + 8'h01;
                    end
                end
            end
        end
    end

    // stop flag follows the verdict of the latest window that asserts fault_set
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_stopped_o <= 1'b0;
        end else if (ce_i) begin
            if (fault_clr) begin
                osc_stopped_o <= 1'b0;
            end else if (fault_set) begin
                osc_stopped_o <= win_stop;
            end
        end
    end

    // sticky until external reset: a fault with pll on may mean the pll is bad
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            force_bypassed <= 1'b0;
        end else if (ce_i && fault_set && use_active) begin
            force_bypassed <= 1'b1;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fault_rst_o  <= 1'b0;
            io_hiz_o     <= 1'b0;
            monitor_on_o <= 1'b0;
        end else if (ce_i) begin
            fault_rst_o  <= fault;
            io_hiz_o     <= fault;
            monitor_on_o <= active;
        end
    end

endmodule

// file: ofm_osc_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// monitored oscillator, period 2*half_i clk
// ----------------------------------------
// a stopped oscillator freezes at its last level, as a dead crystal does
module ofm_osc_model (
    input  wire       clk_i,
    input  wire       run_i,
    input  wire [7:0] half_i,
    output reg        mon_clk_o
);
    reg [7:0] cnt = 8'h00;
    initial mon_clk_o = 1'b0;
    always @(posedge clk_i) begin
        if (run_i) begin
            if (cnt + 8'h01 >= half_i) begin
                cnt <= 8'h00;
                mon_clk_o <= ~mon_clk_o;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end
endmodule

// file: ofm_top_assertions.sv
`timescale 1ns/1ps
`include "ofm_map.vh"
module ofm_chk (
    input wire        clk_i,
    input wire        rst_n_i,
    input wire        ce_i,
    input wire [31:0] addr_i,
    input wire        rd_i,
    input wire [31:0] rdata_o,
    input wire        stop_mode_i,
    input wire        warmup_done_i,
    input wire        fault_rst_o,
    input wire        io_hiz_o,
    input wire        monitor_on_o,
    input wire        osc_stopped_o
);
    // ----------------------------------------
    // run lengths; saturate so long runs never wrap
    // ----------------------------------------
    reg [11:0] on_cnt;
    reg [11:0] flt_cnt;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_cnt <= 12'h000;
            flt_cnt <= 12'h000;
        end else begin
            on_cnt <= monitor_on_o ? on_cnt + {11'h000, ~&on_cnt} : 12'h000;
            flt_cnt <= fault_rst_o ? flt_cnt + {11'h000, ~&flt_cnt} : 12'h000;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    chk_hiz_tracks_fault: assert property (io_hiz_o == fault_rst_o)
        else $error("io release differs from fault reset");
    chk_rdata_idle: assert property (ce_i && !rd_i |=> rdata_o == 32'h0)
        else $error("read data not zero outside read");
    chk_key_legal: assert property (rd_i && ce_i && addr_i == `OFM_ADDR_KEY |=>
        rdata_o == 32'h06 || rdata_o == 32'hF9)
        else $error("key register holds illegal code");
    chk_en_legal: assert property (rd_i && ce_i && addr_i == `OFM_ADDR_EN |=>
        rdata_o == 32'h0 || rdata_o == 32'hE4)
        else $error("enable register holds illegal code");
    chk_fault_persist: assert property ($rose(fault_rst_o) |-> on_cnt >= 12'd600)
        else $error("fault raised before persist time");
    chk_release_persist: assert property ($fell(fault_rst_o) |->
        (flt_cnt >= 12'd600) or (##[0:3] !monitor_on_o))
        else $error("fault released too early");
    chk_stop_suspends: assert property (stop_mode_i [*5] |-> !monitor_on_o)
        else $error("monitor runs in stop mode");
    chk_warm_gate: assert property (!warmup_done_i [*5] |-> !monitor_on_o)
        else $error("monitor runs before warm-up");
    chk_off_clears: assert property ($fell(monitor_on_o) |-> ##[0:2] !fault_rst_o)
        else $error("fault kept with monitor off");
    chk_stop_flag: assert property ($rose(osc_stopped_o) |=> fault_rst_o)
        else $error("stop flag without fault reset");
    cover property ($rose(fault_rst_o));
    cover property ($rose(osc_stopped_o));
    cover property ($fell(fault_rst_o) && monitor_on_o);
endmodule
bind ofm_top ofm_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
    .addr_i(addr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stop_mode_i(stop_mode_i),
    .warmup_done_i(warmup_done_i), .fault_rst_o(fault_rst_o), .io_hiz_o(io_hiz_o),
    .monitor_on_o(monitor_on_o), .osc_stopped_o(osc_stopped_o));

// file: ofm_top_test.sv
`timescale 1ns/1ps
`include "ofm_map.vh"
module ofm_top_test;
    reg         clk_i = 1'b0;
    reg         rst_n_i = 1'b0;
    reg  [31:0] addr_i = 32'h0;
    reg  [31:0] wdata_i = 32'h0;
    reg         wr_i = 1'b0;
    reg         rd_i = 1'b0;
    reg         pll = 1'b0;
    reg         stop = 1'b0;
    reg         warm = 1'b1;
    reg         run = 1'b1;
    reg         ce = 1'b1;
    reg  [7:0]  half = 8'h04;
    wire        mon_clk;
    wire [31:0] rdata_o;
    wire        flt;
    wire        hiz;
    wire        mon_on;
    wire        osc_stop;
    integer     n_checks = 0;
    integer     n_mismatch = 0;
    always #25 clk_i = ~clk_i;
    ofm_osc_model u_osc (.clk_i(clk_i), .run_i(run), .half_i(half), .mon_clk_o(mon_clk));
    ofm_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .mon_clk_i(mon_clk), .pll_active_select_i(pll), .stop_mode_i(stop),
        .warmup_done_i(warm), .fault_rst_o(flt), .io_hiz_o(hiz),
        .monitor_on_o(mon_on), .osc_stopped_o(osc_stop));
    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task check(input string what, input [31:0] exp, input [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input string what, input [31:0] a, input [31:0] exp);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 check(what, exp, rdata_o);
    endtask
    // bounded wait: a window is 160 clk, so 1200 covers persist plus a partial window
    task wait_flt(input v);
        integer i;
        for (i = 0; i < 1200 && flt !== v; i = i + 1)
            @(posedge clk_i);
        #1 check("fault", {31'h0, v}, {31'h0, flt});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_regs;
        rd("key", `OFM_ADDR_KEY, 32'h06);
        rd("en", `OFM_ADDR_EN, 32'h0);
        wr(`OFM_ADDR_LO_BYP, 32'h0F);
        rd("lo_byp", `OFM_ADDR_LO_BYP, `OFM_LO_RST);
        wr(`OFM_ADDR_KEY, 32'h12);
        rd("key", `OFM_ADDR_KEY, 32'h06);
        wr(`OFM_ADDR_KEY, 32'hF9);
        rd("key", `OFM_ADDR_KEY, 32'hF9);
        ce <= 1'b0;
        wr(`OFM_ADDR_KEY, 32'h06);
        ce <= 1'b1;
        rd("key_frozen", `OFM_ADDR_KEY, 32'hF9);
        wr(`OFM_ADDR_EN, 32'h55);
        rd("en", `OFM_ADDR_EN, 32'h0);
        wr(`OFM_ADDR_LO_BYP, 32'h0F);
        wr(`OFM_ADDR_HI_BYP, 32'h19);
        wr(`OFM_ADDR_LO_ACT, 32'h1E);
        wr(`OFM_ADDR_HI_ACT, 32'h8000_0032);
        rd("lo_byp", `OFM_ADDR_LO_BYP, 32'h0F);
        rd("hi_byp", `OFM_ADDR_HI_BYP, 32'h19);
        rd("lo_act", `OFM_ADDR_LO_ACT, 32'h1E);
        rd("hi_act", `OFM_ADDR_HI_ACT, 32'h8000_0032);
        rd("unmapped", 32'h4004_0900, 32'h0);
        wr(`OFM_ADDR_EN, 32'hE4);
        wr(`OFM_ADDR_LO_BYP, 32'h01);
        rd("lo_byp", `OFM_ADDR_LO_BYP, 32'h0F);
        wr(`OFM_ADDR_KEY, 32'h06);
        wr(`OFM_ADDR_EN, 32'h0);
        rd("en", `OFM_ADDR_EN, 32'hE4);
        wr(`OFM_ADDR_KEY, 32'hF9);
        #1 check("mon_on", 32'h1, {31'h0, mon_on});
    endtask
    task t_osc;
        repeat (1000) @(posedge clk_i);
        #1 check("fault", 32'h0, {31'h0, flt});
        run <= 1'b0;
        wait_flt(1'b1);
        check("hiz", 32'h1, {31'h0, hiz});
        check("stopped", 32'h1, {31'h0, osc_stop});
        rd("en", `OFM_ADDR_EN, 32'hE4);
        run <= 1'b1;
        wait_flt(1'b0);
        half <= 8'h02;
        wait_flt(1'b1);
        half <= 8'h04;
        wait_flt(1'b0);
    endtask
    task t_pll;
        wr(`OFM_ADDR_EN, 32'h0);
        pll <= 1'b1;
        repeat (4) @(posedge clk_i);
        wr(`OFM_ADDR_EN, 32'hE4);
        wait_flt(1'b1);
        wait_flt(1'b0);
    endtask
    task t_stop;
        stop <= 1'b1;
        warm <= 1'b0;
        repeat (8) @(posedge clk_i);
        #1 check("mon_on", 32'h0, {31'h0, mon_on});
        stop <= 1'b0;
        repeat (8) @(posedge clk_i);
        #1 check("mon_on", 32'h0, {31'h0, mon_on});
        warm <= 1'b1;
        repeat (8) @(posedge clk_i);
        #1 check("mon_on", 32'h1, {31'h0, mon_on});
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd("key", `OFM_ADDR_KEY, 32'h06);
        rd("en", `OFM_ADDR_EN, 32'h0);
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_osc;
        t_pll;
        t_stop;
        print_verdict;
    end
    initial begin
        #1000000;
        n_mismatch = n_mismatch + 1;
        print_verdict;
    end
endmodule
